// ### logic/ppc_top.sv
/*
  Port power path and attach controller for one USB Type-C port, with an
  AXI4-Lite register slave. Assumes analog comparators and switch drivers
  outside; all comparator inputs are asynchronous to aclk.
*/
// Functional notes
// - Overcurrent clamp enabled at selected limit only while sourcing.
// - Clamp active beyond deglitch time latches the switch off.
// - Overcurrent trip from forward drop latches switch off at once.
// - VBUS over or under voltage disables the high-voltage path.
// - Comparator mode while sourcing, ideal diode while sinking; reverse disables.
// - Comparator mode conducts until reverse threshold, then blocks VBUS to rail.
// - Ideal diode mode blocks rail to VBUS current.
// - External path enable is active high, dropped on voltage faults.
// - Only voltage faults drop external path enables, not current or thermal.
// - VCONN switch current limit active while enabled; no reverse blocking.
// - VCONN closes only with input good; later droop does not reopen.
// - Switch off and VBUS above safe 5 V enables pull-down until reached.
// - Safe zero transition keeps pull-down on until reached, within time limit.
// - Source with both pins open watches both and applies no power.
// - Rd on one pin applies VBUS without VCONN, watches Rd pin.
// - Ra alone applies nothing, watches open pin and Ra pin.
// - Ra and Rd apply VBUS and VCONN on Ra, watch Rd only.
// - Rd-Rd is debug, Ra-Ra is audio; both pins sensed for detach.
// - Source advertises default, 1.5 A or 3 A; thresholds follow.
// - Pin below active cable level is a cable, not a sink.
// - Outside Rd-Rd debug, monitored pin above detach level registers disconnection.
// - Sink presents Rd both pins, VBUS is attach, decodes advertised current.
`timescale 1ns/1ns
`include "ppc_params.svh"
module ppc_top
  import ppc_pkg::*;
#(
  parameter int DEGLITCH_CYC = `PPC_DEGLITCH_CYC,
  parameter int SAFE0V_CYC = `PPC_SAFE0V_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clamp_active,
  input wire logic overcurrent_trip,
  input wire logic vbus_over_voltage,
  input wire logic vbus_under_voltage,
  input wire logic reverse_current,
  input wire logic vconn_input_good,
  input wire logic vbus_above_safe5v,
  input wire logic vbus_above_safe0v,
  input wire logic vbus_present,
  input wire logic [1:0] cc_below_sink,
  input wire logic [1:0] cc_below_cable,
  input wire logic [1:0] cc_pullup_level,
  output logic high_voltage_power_path,
  output logic clamp_enable,
  output logic [1:0] clamp_current_limit,
  output logic rcp_comparator_mode,
  output logic external_path_enable,
  output logic [1:0] vconn_supply_switch,
  output logic vconn_current_limit,
  output logic vbus_pulldown,
  output logic [1:0] cc_pullup_current,
  output logic [1:0] cc_monitor,
  output logic trimmed_sink_pulldown,
  output logic [7:0] ov_threshold,
  output logic [7:0] uv_threshold
);
  localparam int NS = 15;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  logic s_clamp, s_ocp, s_ov, s_uv, s_rev, s_good, s_5v, s_0v;
  logic [1:0] s_lvl;
  logic [31:0] ctrl_q;
  logic [31:0] thresh_q;
  logic [`PPC_NEV-1:0] ev_q;
  logic [`PPC_NEV-1:0] ev_set;
  logic hv_latch_q;
  logic ext_latch_q;
  logic [31:0] dg_cnt_q;
  logic [31:0] s0_cnt_q;
  logic s0_active_q;
  logic att_q;
  logic [1:0] ufp_adv_q;
  logic aw_have_q, w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic en, src, dfp;
  logic hv_d;
  ppc_cc_if cc ();
  assign raw = {cc_pullup_level, vbus_present, cc_below_cable, cc_below_sink, clamp_active,
    overcurrent_trip, vbus_over_voltage, vbus_under_voltage, reverse_current,
    vconn_input_good, vbus_above_safe5v, vbus_above_safe0v};
  ppc_sync #(.W(NS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(raw),
    .sync_out(syn)
  );
  assign {s_lvl, cc.vbus_present, cc.below_cable, cc.below_sink, s_clamp, s_ocp, s_ov, s_uv,
    s_rev, s_good, s_5v, s_0v} = syn;
  assign cc.dfp_mode = dfp;
  ppc_cc_decode u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .cc(cc)
  );
  assign en = ctrl_q[`PPC_CTRL_EN];
  assign src = ctrl_q[`PPC_CTRL_SRC];
  assign dfp = ctrl_q[`PPC_CTRL_DFP];
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // AXI write channels, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_q)
          `PPC_OFF_CTRL, `PPC_OFF_STATUS, `PPC_OFF_EVENT, `PPC_OFF_THRESH:
            s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Control and threshold registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `PPC_CTRL_RST;
      thresh_q <= `PPC_THRESH_RST;
    end else if (wr_fire) begin
      if (awaddr_q == `PPC_OFF_CTRL) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_03ff;
      end
      if (awaddr_q == `PPC_OFF_THRESH) begin
        thresh_q <= merge(thresh_q, wdata_q, wstrb_q) & 32'h0000_ffff;
      end
    end
  end
  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        `PPC_OFF_CTRL: s_axi_rdata <= ctrl_q;
        `PPC_OFF_STATUS: s_axi_rdata <= {20'h0_0000, cc.conn, ufp_adv_q, cc.attached,
          s0_active_q, vbus_pulldown, ext_latch_q, hv_latch_q, high_voltage_power_path};
        `PPC_OFF_EVENT: s_axi_rdata <= {24'h00_0000, ev_q};
        `PPC_OFF_THRESH: s_axi_rdata <= thresh_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dg_cnt_q <= 32'h0000_0000;
    end else if (s_clamp && clamp_enable) begin
      if (dg_cnt_q <= 32'(DEGLITCH_CYC)) begin
        dg_cnt_q <= dg_cnt_q + 32'h0000_0001;
      end
    end else begin
      dg_cnt_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hv_latch_q <= 1'b0;
    end else if (s_ocp || dg_cnt_q > 32'(DEGLITCH_CYC) || s_ov || s_uv) begin
      hv_latch_q <= 1'b1;
    end else if (!en) begin
      hv_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_latch_q <= 1'b0;
    end else if (s_ov || s_uv) begin
      ext_latch_q <= 1'b1;
    end else if (!en) begin
      ext_latch_q <= 1'b0;
    end
  end

  assign hv_d = en && !ctrl_q[`PPC_CTRL_EXT] && !hv_latch_q && !s_ov && !s_uv &&
    !s_ocp && !s_rev && (!(src && dfp) || cc.vbus_apply);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_voltage_power_path <= 1'b0;
      clamp_enable <= 1'b0;
      clamp_current_limit <= 2'h0;
      rcp_comparator_mode <= 1'b0;
      external_path_enable <= 1'b0;
    end else begin
      high_voltage_power_path <= hv_d;
      clamp_enable <= hv_d && src;
      clamp_current_limit <= ctrl_q[`PPC_CTRL_CLAMP +: 2];
      rcp_comparator_mode <= src;
      external_path_enable <= en && ctrl_q[`PPC_CTRL_EXT] && !ext_latch_q && !s_ov &&
        !s_uv && (!(src && dfp) || cc.vbus_apply);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vconn_supply_switch <= 2'h0;
      vconn_current_limit <= 1'b0;
    end else if (!(en && dfp && ctrl_q[`PPC_CTRL_VCONN]) || cc.vconn_pin == 2'h0) begin
      vconn_supply_switch <= 2'h0;
      vconn_current_limit <= 1'b0;
    end else if (vconn_supply_switch == 2'h0 && s_good) begin
      vconn_supply_switch <= cc.vconn_pin;
      vconn_current_limit <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbus_pulldown <= 1'b0;
      s0_active_q <= 1'b0;
      s0_cnt_q <= 32'h0000_0000;
    end else begin
      s0_active_q <= !hv_d && ctrl_q[`PPC_CTRL_SAFE0] && s_0v;
      vbus_pulldown <= !hv_d && (ctrl_q[`PPC_CTRL_SAFE0] ? s_0v : s_5v);
      if (s0_active_q) begin
        if (s0_cnt_q <= 32'(SAFE0V_CYC)) begin
          s0_cnt_q <= s0_cnt_q + 32'h0000_0001;
        end
      end else begin
        s0_cnt_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_pullup_current <= 2'h0;
      cc_monitor <= 2'h0;
      trimmed_sink_pulldown <= 1'b0;
      ufp_adv_q <= 2'h0;
      ov_threshold <= 8'h00;
      uv_threshold <= 8'h00;
      att_q <= 1'b0;
    end else begin
      cc_pullup_current <= ctrl_q[`PPC_CTRL_RP +: 2];
      cc_monitor <= dfp ? cc.monitor : 2'h3;
      trimmed_sink_pulldown <= !dfp;
      ufp_adv_q <= (!dfp && cc.attached) ? s_lvl : 2'h0;
      ov_threshold <= thresh_q[15:8];
      uv_threshold <= thresh_q[7:0];
      att_q <= cc.attached;
    end
  end
  always_comb begin
    ev_set[`PPC_EV_OCP] = s_ocp;
    ev_set[`PPC_EV_CLAMP] = dg_cnt_q == 32'(DEGLITCH_CYC) + 32'h0000_0001;
    ev_set[`PPC_EV_OV] = s_ov;
    ev_set[`PPC_EV_UV] = s_uv;
    ev_set[`PPC_EV_REV] = s_rev;
    ev_set[`PPC_EV_ATT] = cc.attached && !att_q;
    ev_set[`PPC_EV_DET] = !cc.attached && att_q;
    ev_set[`PPC_EV_S0TO] = s0_cnt_q == 32'(SAFE0V_CYC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= '0;
    end else if (wr_fire && awaddr_q == `PPC_OFF_EVENT && wstrb_q[0]) begin
      ev_q <= (ev_q & ~wdata_q[`PPC_NEV-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end
endmodule

// ### logic/ppc_params.svh
/*
  Offsets, field positions, reset values and timing figures of the port
  power and attach controller. Assumes a 25 MHz aclk.
*/
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
`define PPC_CLK_NS 40
`define PPC_OFF_CTRL 12'h000
`define PPC_OFF_STATUS 12'h004
`define PPC_OFF_EVENT 12'h008
`define PPC_OFF_THRESH 12'h00c
`define PPC_CTRL_EN 0
`define PPC_CTRL_SRC 1
`define PPC_CTRL_EXT 2
`define PPC_CTRL_DFP 3
`define PPC_CTRL_RP 4
`define PPC_CTRL_CLAMP 6
`define PPC_CTRL_VCONN 8
`define PPC_CTRL_SAFE0 9
`define PPC_CTRL_RST 32'h0000_0000
`define PPC_THRESH_RST 32'h0000_0000
`define PPC_EV_OCP 0
`define PPC_EV_CLAMP 1
`define PPC_EV_OV 2
`define PPC_EV_UV 3
`define PPC_EV_REV 4
`define PPC_EV_ATT 5
`define PPC_EV_DET 6
`define PPC_EV_S0TO 7
`define PPC_NEV 8
`define PPC_DEGLITCH_NS 10000
`define PPC_DEGLITCH_CYC ((`PPC_DEGLITCH_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_SAFE0V_MS 100
`define PPC_SAFE0V_CYC ((`PPC_SAFE0V_MS * 1000000) / `PPC_CLK_NS)
`endif

// ### logic/ppc_pkg.sv
/*
  Types shared by the port power and attach controller modules.
  Assumes the constants of ppc_params.svh.
*/
package ppc_pkg;
  typedef enum logic [1:0] {PPC_CC_OPEN, PPC_CC_RD, PPC_CC_RA} ppc_cc_t;
  typedef enum logic [3:0] {
    PPC_NONE, PPC_SINK1, PPC_SINK2, PPC_CABLE1, PPC_CABLE2,
    PPC_CSINK1, PPC_CSINK2, PPC_DEBUG, PPC_AUDIO, PPC_UFP
  } ppc_conn_t;
endpackage

// ### logic/ppc_cc_if.sv
/*
  Carrier between the controller top and its CC attach decoder.
  Assumes both ends run on the same aclk.
*/
`timescale 1ns/1ns
interface ppc_cc_if;
  import ppc_pkg::*;
  logic [1:0] below_sink;
  logic [1:0] below_cable;
  logic dfp_mode;
  logic vbus_present;
  ppc_conn_t conn;
  logic attached;
  logic vbus_apply;
  logic [1:0] vconn_pin;
  logic [1:0] monitor;
  modport top (output below_sink, below_cable, dfp_mode, vbus_present,
    input conn, attached, vbus_apply, vconn_pin, monitor);
  modport dec (input below_sink, below_cable, dfp_mode, vbus_present,
    output conn, attached, vbus_apply, vconn_pin, monitor);
endinterface

// ### logic/ppc_sync.sv
/*
  Three-flop synchroniser for asynchronous comparator outputs.
  A change is accepted once the second and third stages agree.
*/
`timescale 1ns/1ns
module ppc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ### logic/ppc_cc_decode.sv
/*
  CC connection decoder: classifies each CC pin as open, Rd or Ra and
  tracks the connection state. Assumes synchronised comparator inputs.
*/
`timescale 1ns/1ns
module ppc_cc_decode
  import ppc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  ppc_cc_if.dec cc
);
  ppc_cc_t p1;
  ppc_cc_t p2;
  ppc_conn_t conn_d;

  function automatic ppc_cc_t pin_kind(input logic sink, input logic cable);
    if (cable) begin
      return PPC_CC_RA;
    end
    return sink ? PPC_CC_RD : PPC_CC_OPEN;
  endfunction

  always_comb begin
    p1 = pin_kind(cc.below_sink[0], cc.below_cable[0]);
    p2 = pin_kind(cc.below_sink[1], cc.below_cable[1]);
    conn_d = PPC_NONE;
    if (!cc.dfp_mode) begin
      conn_d = cc.vbus_present ? PPC_UFP : PPC_NONE;
    end else if (p1 == PPC_CC_RD && p2 == PPC_CC_OPEN) begin
      conn_d = PPC_SINK1;
    end else if (p1 == PPC_CC_OPEN && p2 == PPC_CC_RD) begin
      conn_d = PPC_SINK2;
    end else if (p1 == PPC_CC_RA && p2 == PPC_CC_OPEN) begin
      conn_d = PPC_CABLE1;
    end else if (p1 == PPC_CC_OPEN && p2 == PPC_CC_RA) begin
      conn_d = PPC_CABLE2;
    end else if (p1 == PPC_CC_RA && p2 == PPC_CC_RD) begin
      conn_d = PPC_CSINK2;
    end else if (p1 == PPC_CC_RD && p2 == PPC_CC_RA) begin
      conn_d = PPC_CSINK1;
    end else if (p1 == PPC_CC_RD && p2 == PPC_CC_RD) begin
      conn_d = PPC_DEBUG;
    end else if (p1 == PPC_CC_RA && p2 == PPC_CC_RA) begin
      conn_d = PPC_AUDIO;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc.conn <= PPC_NONE;
    end else begin
      cc.conn <= conn_d;
    end
  end

  always_comb begin
    cc.attached = cc.conn != PPC_NONE && cc.conn != PPC_CABLE1 && cc.conn != PPC_CABLE2;
    cc.vbus_apply = 1'b0;
    cc.vconn_pin = 2'h0;
    cc.monitor = 2'h3;
    unique case (cc.conn)
      PPC_NONE, PPC_UFP: ;
      PPC_SINK1: begin
        cc.vbus_apply = 1'b1;
        cc.monitor = 2'h1;
      end
      PPC_SINK2: begin
        cc.vbus_apply = 1'b1;
        cc.monitor = 2'h2;
      end
      PPC_CABLE1, PPC_CABLE2: ;
      PPC_CSINK1: begin
        cc.vbus_apply = 1'b1;
        cc.vconn_pin = 2'h2;
        cc.monitor = 2'h1;
      end
      PPC_CSINK2: begin
        cc.vbus_apply = 1'b1;
        cc.vconn_pin = 2'h1;
        cc.monitor = 2'h2;
      end
      PPC_DEBUG, PPC_AUDIO: ;
      default: ;
    endcase
  end
endmodule

// ### tb/ppc_top_assertions.sv
/* Port-level checker for ppc_top.
   Assumes it is bound to ppc_top and sees only its ports. */
`timescale 1ns/1ns
module ppc_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic overcurrent_trip,
  input wire logic vbus_over_voltage,
  input wire logic vbus_under_voltage,
  input wire logic vconn_input_good,
  input wire logic vbus_above_safe5v,
  input wire logic vbus_above_safe0v,
  input wire logic [1:0] cc_below_sink,
  input wire logic [1:0] cc_below_cable,
  input wire logic high_voltage_power_path,
  input wire logic clamp_enable,
  input wire logic rcp_comparator_mode,
  input wire logic external_path_enable,
  input wire logic [1:0] vconn_supply_switch,
  input wire logic vconn_current_limit,
  input wire logic vbus_pulldown,
  input wire logic trimmed_sink_pulldown
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_clamp_src_only: assert property (clamp_enable |-> rcp_comparator_mode)
    else $error("clamp enabled while sinking");
  a_trip_path_off: assert property (overcurrent_trip [*8] |-> !high_voltage_power_path)
    else $error("path on during overcurrent trip");
  a_volt_fault_off: assert property ((vbus_over_voltage || vbus_under_voltage) [*8]
    |-> !high_voltage_power_path && !external_path_enable)
    else $error("path on during voltage fault");
  a_vconn_need_good: assert property (!vconn_input_good [*8]
    |-> !$rose(|vconn_supply_switch))
    else $error("vconn closed without input good");
  a_vconn_limit_on: assert property ((|vconn_supply_switch)
    && $past(|vconn_supply_switch) |-> vconn_current_limit)
    else $error("vconn on without current limit");
  a_vconn_ra_pin: assert property ($stable(cc_below_cable) [*8]
    |-> (vconn_supply_switch & ~cc_below_cable) == 2'h0)
    else $error("vconn on a pin without cable");
  a_pulldown_idle: assert property ((!vbus_above_safe5v && !vbus_above_safe0v) [*8]
    |-> !vbus_pulldown)
    else $error("pull-down on at zero volts");
  a_pulldown_path: assert property (high_voltage_power_path [*3] |-> !vbus_pulldown)
    else $error("pull-down on with path on");
  a_no_attach_idle: assert property (
    (!trimmed_sink_pulldown && cc_below_sink == 2'h0) [*8]
    |-> !high_voltage_power_path && vconn_supply_switch == 2'h0)
    else $error("power applied with nothing attached");
endmodule
bind ppc_top ppc_top_assertions u_chk (.*);

// ### tb/ppc_partner.sv
/* Behavioural port partner: CC terminations and the VBUS level.
   Assumes the bench picks the terminations; VBUS decays only under pull-down. */
`timescale 1ns/1ns
module ppc_partner
  import ppc_pkg::*;
(
  input wire logic aclk,
  input wire ppc_cc_t t1,
  input wire ppc_cc_t t2,
  input wire logic hv,
  input wire logic pd,
  output logic [1:0] below_sink,
  output logic [1:0] below_cable,
  output logic above5,
  output logic above0
);
  int lvl = 0;
  // Ra pulls below both thresholds, Rd only below the sink one
  assign below_sink = {t2 != PPC_CC_OPEN, t1 != PPC_CC_OPEN};
  assign below_cable = {t2 == PPC_CC_RA, t1 == PPC_CC_RA};
  // Slow decay so a late pull-down turn-off still leaves charge above zero
  always @(posedge aclk) begin
    if (hv) lvl <= 80;
    else if (pd && lvl > 0) lvl <= lvl - 1;
  end
  assign above5 = lvl > 20;
  assign above0 = lvl > 0;
endmodule

// ### tb/tb_ppc_top.sv
/* Self-checking bench for ppc_top over AXI4-Lite and the comparator inputs.
   Assumes ppc_partner stands on the CC and VBUS side. */
`timescale 1ns/1ns
`include "ppc_params.svh"
module tb_ppc_top;
  import ppc_pkg::*;
  localparam logic [11:0] CTL = `PPC_OFF_CTRL, STS = `PPC_OFF_STATUS;
  localparam logic [11:0] EVT = `PPC_OFF_EVENT, THR = `PPC_OFF_THRESH;
  localparam logic [31:0] DFPSRC = (32'h1 << `PPC_CTRL_EN) | (32'h1 << `PPC_CTRL_SRC)
    | (32'h1 << `PPC_CTRL_DFP) | (32'h1 << `PPC_CTRL_VCONN);
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h21, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cc_pullup_level = 2'h0;
  logic clamp_active = 1'b0, overcurrent_trip = 1'b0, vbus_over_voltage = 1'b0;
  logic vbus_under_voltage = 1'b0, reverse_current = 1'b0, vconn_input_good = 1'b0;
  logic vbus_present = 1'b0, vbus_above_safe5v, vbus_above_safe0v;
  logic [1:0] cc_below_sink, cc_below_cable, clamp_current_limit, vconn_supply_switch;
  logic [1:0] cc_pullup_current, cc_monitor;
  logic high_voltage_power_path, clamp_enable, rcp_comparator_mode, external_path_enable;
  logic vconn_current_limit, vbus_pulldown, trimmed_sink_pulldown;
  logic [7:0] ov_threshold, uv_threshold;
  ppc_cc_t t1 = PPC_CC_OPEN, t2 = PPC_CC_OPEN;
  int bad_count = 0, num_checks = 0;
  int evb[4] = '{`PPC_EV_OV, `PPC_EV_UV, `PPC_EV_OCP, `PPC_EV_CLAMP};
  ppc_top #(.DEGLITCH_CYC(8), .SAFE0V_CYC(50)) u_dut (.*);
  ppc_partner u_prt (.aclk, .t1, .t2, .hv(high_voltage_power_path | external_path_enable),
    .pd(vbus_pulldown), .below_sink(cc_below_sink), .below_cable(cc_below_cable),
    .above5(vbus_above_safe5v), .above0(vbus_above_safe0v));
  always #20 aclk = ~aclk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic ex_vbus(ppc_cc_t a, ppc_cc_t b);
    return (a == PPC_CC_RD) != (b == PPC_CC_RD);
  endfunction
  function logic [1:0] ex_vconn(ppc_cc_t a, ppc_cc_t b);
    if (a == PPC_CC_RA && b == PPC_CC_RD) return 2'h1;
    if (a == PPC_CC_RD && b == PPC_CC_RA) return 2'h2;
    return 2'h0;
  endfunction
  function logic [1:0] ex_mon(ppc_cc_t a, ppc_cc_t b);
    if (ex_vbus(a, b)) return {b == PPC_CC_RD, a == PPC_CC_RD};
    return 2'h3;
  endfunction
  task chk(input logic ok, input string s);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === er, "write response");
    cyc(1);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er, input string s);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk((((s_axi_rdata ^ e) & m) === 32'h0) && (s_axi_rresp === er), s);
  endtask
  task reenable(input logic [31:0] v);
    wr(CTL, 32'h0, 2'h0);
    wr(CTL, v, 2'h0);
    cyc(12);
  endtask
  initial begin
    #200000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    cyc(3);
    aresetn <= 1'b1;
    rc(CTL, 32'h0, 32'hffffffff, 2'h0, "ctrl reset");
    rc(THR, 32'h0, 32'hffff, 2'h0, "thresh reset");
    d = rnd();
    wr(THR, d, 2'h0);
    chk(ov_threshold === d[15:8] && uv_threshold === d[7:0], "thresholds");
    rc(THR, d, 32'hffff, 2'h0, "thresh readback");
    wr(12'h010, rnd(), 2'h2);
    rc(12'h010, 32'h0, 32'hffffffff, 2'h2, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(CTL, (i << 4) | (d[1:0] << 6), 2'h0);
      chk(cc_pullup_current === i[1:0] && clamp_current_limit === d[1:0], "levels");
    end
    $display("test registers done");
    vconn_input_good <= 1'b1;
    wr(CTL, DFPSRC, 2'h0);
    for (int i = 0; i < 9; i++) begin
      t1 <= PPC_CC_OPEN;
      t2 <= PPC_CC_OPEN;
      cyc(12);
      t1 <= ppc_cc_t'(i % 3);
      t2 <= ppc_cc_t'(i / 3);
      cyc(14);
      chk(high_voltage_power_path === ex_vbus(t1, t2), "vbus apply");
      chk(vconn_supply_switch === ex_vconn(t1, t2), "vconn apply");
      chk(cc_monitor === ex_mon(t1, t2), "monitored pins");
      chk(rcp_comparator_mode === 1'b1, "source rcp mode");
    end
    t1 <= PPC_CC_OPEN;
    t2 <= PPC_CC_OPEN;
    cyc(12);
    rc(EVT, 32'h60, 32'h60, 2'h0, "attach events");
    wr(EVT, 32'hff, 2'h0);
    $display("test attach done");
    t1 <= PPC_CC_RA;
    t2 <= PPC_CC_RD;
    vconn_input_good <= 1'b0;
    reenable(DFPSRC);
    chk(vconn_supply_switch === 2'h0, "vconn without good");
    vconn_input_good <= 1'b1;
    cyc(12);
    chk(vconn_supply_switch === 2'h1, "vconn closes");
    vconn_input_good <= 1'b0;
    cyc(12);
    chk(vconn_supply_switch === 2'h1, "vconn held");
    chk(vconn_current_limit === 1'b1, "vconn limited");
    $display("test vconn done");
    t1 <= PPC_CC_RD;
    t2 <= PPC_CC_OPEN;
    reenable(DFPSRC);
    clamp_active <= 1'b1;
    cyc(3);
    clamp_active <= 1'b0;
    cyc(12);
    chk(high_voltage_power_path === 1'b1, "short clamp kept path");
    for (int i = 0; i < 4; i++) begin
      reenable(DFPSRC);
      chk(high_voltage_power_path === 1'b1, "path on");
      {clamp_active, overcurrent_trip, vbus_under_voltage, vbus_over_voltage} <= 4'h1 << i;
      cyc(18);
      {clamp_active, overcurrent_trip, vbus_under_voltage, vbus_over_voltage} <= 4'h0;
      cyc(12);
      chk(high_voltage_power_path === 1'b0, "latched off");
      rc(EVT, 32'h1 << evb[i], 32'h1 << evb[i], 2'h0, "fault event");
      wr(EVT, 32'hff, 2'h0);
    end
    reenable(DFPSRC);
    reverse_current <= 1'b1;
    cyc(10);
    chk(high_voltage_power_path === 1'b0, "reverse blocks");
    reverse_current <= 1'b0;
    cyc(10);
    chk(high_voltage_power_path === 1'b1, "reverse released");
    rc(EVT, 32'h1 << `PPC_EV_REV, 32'h1 << `PPC_EV_REV, 2'h0, "reverse event");
    reenable(DFPSRC | (32'h1 << `PPC_CTRL_EXT));
    chk(external_path_enable === 1'b1, "ext on");
    overcurrent_trip <= 1'b1;
    cyc(12);
    chk(external_path_enable === 1'b1, "ext ignores overcurrent");
    overcurrent_trip <= 1'b0;
    vbus_under_voltage <= 1'b1;
    cyc(12);
    chk(external_path_enable === 1'b0, "ext drops on uv");
    vbus_under_voltage <= 1'b0;
    $display("test faults done");
    reenable(DFPSRC);
    t1 <= PPC_CC_OPEN;
    cyc(80);
    chk(!vbus_above_safe5v && vbus_above_safe0v && !vbus_pulldown, "safe 5v stop");
    wr(CTL, DFPSRC | (32'h1 << `PPC_CTRL_SAFE0), 2'h0);
    cyc(50);
    chk(vbus_above_safe0v === 1'b0 && vbus_pulldown === 1'b0, "safe 0v reached");
    $display("test discharge done");
    d = rnd();
    cc_pullup_level <= d[1:0];
    vbus_present <= 1'b1;
    reenable(32'h1 << `PPC_CTRL_EN);
    chk(trimmed_sink_pulldown === 1'b1, "sink mode");
    chk(rcp_comparator_mode === 1'b0, "ideal diode mode");
    chk(clamp_enable === 1'b0, "no clamp sinking");
    rc(STS, {PPC_UFP, d[1:0], 1'b1, 5'h0}, 32'hfe0, 2'h0, "sink status");
    $display("test sink done");
    end_sim();
  end
endmodule
